//--- sil_flag_cell.sv
// One status flag: latched event, optionally following its condition after clear
`timescale 1ns/1ps
module sil_flag_cell
#(
  parameter bit HOLD = 1'b0  // Reflect condition after clear
)(
  input  wire logic clk,   // System clock
  input  wire logic reset, // Async reset, active high
  input  wire logic set,   // Event pulse
  input  wire logic clr,   // Read-only clear pulse
  input  wire logic cond,  // Present condition level
  output logic      flag   // Status bit
);
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clr)
      flag <= HOLD & cond;
  end

  a_flag_set_wins : assert property (@(posedge clk) disable iff (reset)
    set |=> flag) else $error("flag event lost");
  a_flag_clear : assert property (@(posedge clk) disable iff (reset)
    (clr && !set && !(HOLD && cond)) |=> !flag) else $error("flag not cleared");
endmodule // sil_flag_cell

//--- sil_host_model.sv
// Host side of the alert line: pull-up and configuration strap
`timescale 1ns/1ps
module sil_host_model
(
  input  wire logic alert_oe,       // Device pulls the line low
  input  wire logic reset_out_line, // Host released from reset
  input  wire logic cfg_level,      // Strap level during init
  output logic      alert_wire      // Resolved line level
);
  // pull-up once device lets go
  // The strap only stands while reset output is low, so a stale level never leaks into run time
  always_comb
    alert_wire = alert_oe ? 1'h0 : (reset_out_line ? 1'h1 : cfg_level);
endmodule // sil_host_model

//--- sil_interrupt_logic.sv
// SBC interrupt collection, alert pin control and register slave
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Contract
// - Enabled events drive alert line low
// - Each source has own mask bit
// - Masked source still sets status bit
// - Undervoltage alerts on begin and end
// - State flags latch, then follow condition
// - Event flags cleared by read-only access
// - Alert released by clear read or timeout
// - Wake flags in reg zero, summary flag
// - Summary clears when registers one, two empty
// - Several sources give one alert pulse
// - Alert low no longer than timeout
// - Gap between alerts at least timeout
// - Alert pulse lasts minimum width
// - Alerts only in normal or stop mode
// - Leaving restart enables all masks
// - Switch-off silent, switch-on raises alert
// - Switch-on flag holds during undervoltage
// - Reset event only in development mode
// - Alert pin selects configuration during init
// - Timeout period six milliseconds
// - Minimum pulse width ten microseconds
// - All sources enabled after reset
module sil_interrupt_logic
#(
  parameter int TIMEOUT_CYC = sil_pkg::ALERT_TIMEOUT_CYC  // Alert timeout and gap in clocks
)(
  input  wire logic                     clk,           // 20 MHz system clock
  input  wire logic                     reset,         // Async reset, active high
  input  wire logic [sil_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic                     s_axi_awvalid, // Write address valid
  output logic                          s_axi_awready, // Write address ready
  input  wire logic [sil_pkg::DATA_W-1:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]               s_axi_wstrb,   // Write byte strobes
  input  wire logic                     s_axi_wvalid,  // Write data valid
  output logic                          s_axi_wready,  // Write data ready
  output logic [1:0]                    s_axi_bresp,   // Write response
  output logic                          s_axi_bvalid,  // Write response valid
  input  wire logic                     s_axi_bready,  // Write response ready
  input  wire logic [sil_pkg::ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic                     s_axi_arvalid, // Read address valid
  output logic                          s_axi_arready, // Read address ready
  output logic [sil_pkg::DATA_W-1:0]    s_axi_rdata,   // Read data
  output logic [1:0]                    s_axi_rresp,   // Read response
  output logic                          s_axi_rvalid,  // Read data valid
  input  wire logic                     s_axi_rready,  // Read data ready
  input  wire sil_pkg::sil_src_s        src,           // Source condition levels
  input  wire logic                     aux2_en,       // Regulator 2 switched on
  input  wire logic                     aux3_en,       // Regulator 3 switched on
  input  wire logic                     aux2_on_cmd,   // Switch-on command executed, pulse
  input  wire logic                     aux3_on_cmd,   // Switch-on command executed, pulse
  input  wire sil_pkg::sil_mode_t       sbc_mode,      // Chip operating mode
  input  wire logic                     sw_dev_mode,   // Software development mode
  input  wire logic                     reset_out_line,// Reset output released, high
  input  wire logic                     alert_in,      // Alert pin level
  output logic                          alert_out,     // Alert pin drive value
  output logic                          alert_oe,      // Alert pin pulled low when high
  output logic                          cfg_sel        // Sampled configuration select
);
  import sil_pkg::*;

  // Channel handshakes
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;

  logic              have_aw;
  logic              have_w;
  logic              next_have_aw;
  logic              next_have_w;
  logic              next_bvalid;
  logic              next_rvalid;
  logic              wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;

  // Address and data may arrive in either order; the write acts once both are held
  always_comb
  begin
    wr_go        = have_aw & have_w & ~s_axi_bvalid;
    next_have_aw = (have_aw | aw_fire) & ~wr_go;
    next_have_w  = (have_w | w_fire) & ~wr_go;
    next_bvalid  = wr_go | (s_axi_bvalid & ~s_axi_bready);
    next_rvalid  = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  end

  // Write channel state; ready stays low while a response is owed
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      have_aw       <= next_have_aw;
      have_w        <= next_have_w;
      s_axi_awready <= ~next_have_aw & ~next_bvalid;
      s_axi_wready  <= ~next_have_w & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (wr_go)
        s_axi_bresp <= (wr_addr <= OFS_INFO && wr_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Write payload capture
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else
    begin
      if (aw_fire)
        wr_addr <= s_axi_awaddr;
      if (w_fire)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // Source edges; inputs are synchronous
  logic [N_SRC-1:0] lvl;
  logic [N_SRC-1:0] lvl_prev;
  logic [N_SRC-1:0] rise;
  logic [N_SRC-1:0] fall;
  logic [N_SRC-1:0] uv_en;
  logic [N_SRC-1:0] swon;
  logic [N_SRC-1:0] set_vec;
  logic [N_SRC-1:0] alert_ev;
  logic [N_SRC-1:0] flags;
  logic [N_SRC-1:0] mask;
  logic [N_SRC-1:0] hold_cond;
  logic             rd_clr;
  logic             mode_ok;
  logic             summary;

  assign lvl = src;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lvl_prev <= '0;
    else
      lvl_prev <= lvl;
  end

  // Undervoltage edges count only while the regulator is on, so switching off stays silent
  always_comb
  begin
    rise                   = lvl & ~lvl_prev;
    fall                   = ~lvl & lvl_prev;
    uv_en                  = ~UV_BITS;
    uv_en[IDX_AUX2_UV]     = aux2_en;
    uv_en[IDX_AUX3_UV]     = aux3_en;
    swon                   = '0;
    swon[IDX_AUX2_UV]      = aux2_on_cmd;
    swon[IDX_AUX3_UV]      = aux3_on_cmd;
    set_vec                = (rise & uv_en) | swon;
    set_vec[IDX_RST_EV]    = rise[IDX_RST_EV] & sw_dev_mode;
    alert_ev               = (set_vec | (fall & uv_en & UV_BITS)) & mask;
    hold_cond              = lvl & ~MASK_ALL;
    hold_cond[IDX_FL-1:IDX_ST] = lvl[IDX_FL-1:IDX_ST];
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++)
    begin : g_flag
      sil_flag_cell #(
        .HOLD (gi >= IDX_ST && gi < IDX_FL)
      ) u_flag (
        .clk   (clk),
        .reset (reset),
        .set   (set_vec[gi]),
        .clr   (rd_clr),
        .cond  (hold_cond[gi]),
        .flag  (flags[gi])
      );
    end
  endgenerate

  // summary of registers one and two
  assign summary = |flags[N_SRC-1:IDX_ST];

  // Mask register; leaving restart overrides a same-cycle write
  sil_mode_t mode_prev;
  logic      restart_exit;
  assign restart_exit = (mode_prev == MODE_RESTART) && (sbc_mode != MODE_RESTART);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_prev <= MODE_INIT;
      mask      <= MASK_ALL;
    end
    else
    begin
      mode_prev <= sbc_mode;
      if (restart_exit)
        mask <= MASK_ALL;
      else if (wr_go && wr_addr == OFS_MASK)
      begin
        if (wr_strb[0])
          mask[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          mask[N_SRC-1:8] <= wr_data[N_SRC-1:8];
      end
    end
  end

  // Alert sequencer
  sil_alert_e st;
  sil_alert_e next_st;
  logic       pend;
  logic       rd_seen;
  logic       long_done;
  logic       short_done;
  logic       go_low;
  logic       go_gap;

  assign mode_ok = ((sbc_mode == MODE_NORMAL) || (sbc_mode == MODE_STOP)) && reset_out_line;

  always_comb
  begin
    next_st = st;
    case (st)
      ST_IDLE:
        if (pend && mode_ok)
          next_st = ST_LOW;
      // release on read after minimum, or on timeout
      ST_LOW:
        if (long_done || ((rd_seen || rd_clr) && short_done))
          next_st = ST_GAP;
      ST_GAP:
        if (long_done)
          next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
    go_low = (st == ST_IDLE) && (next_st == ST_LOW);
    go_gap = (st == ST_LOW) && (next_st == ST_GAP);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st <= ST_IDLE;
    else
      st <= next_st;
  end

  // pending events merge into one pulse; an event at pulse start is kept
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pend <= 1'b0;
    else if ((|alert_ev) && mode_ok)
      pend <= 1'b1;
    else if (go_low)
      pend <= 1'b0;
  end

  // A read during the pulse is remembered until the minimum width has passed
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rd_seen <= 1'b0;
    else if (go_low)
      rd_seen <= 1'b0;
    else if (rd_clr && st == ST_LOW)
      rd_seen <= 1'b1;
  end

  // timeout timer, restarted at pulse start and at release
  sil_timer #(
    .WIDTH (TMR_W),
    .COUNT (TIMEOUT_CYC - 1)
  ) u_long (
    .clk     (clk),
    .reset   (reset),
    .restart (go_low || go_gap),
    .done    (long_done)
  );

  sil_timer #(
    .WIDTH (TMR_W),
    .COUNT (MIN_PULSE_CYC - 1)
  ) u_short (
    .clk     (clk),
    .reset   (reset),
    .restart (go_low),
    .done    (short_done)
  );

  // Pin drive is open drain: only ever pulled low
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      alert_out <= 1'b0;
      alert_oe  <= 1'b0;
    end
    else
    begin
      alert_out <= 1'b0;
      alert_oe  <= (next_st == ST_LOW) && reset_out_line;
    end
  end

  // configuration sampled while reset output is low
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cfg_sel <= 1'b0;
    else if (!reset_out_line)
      cfg_sel <= alert_in;
  end

  // Read channel; reading the clear alias is the read-only command to register zero
  logic [DATA_W-1:0] rd_word;
  logic [1:0]        rd_resp;
  assign rd_clr = ar_fire && (s_axi_araddr == OFS_CLR0);

  always_comb
  begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    case (s_axi_araddr)
      OFS_STAT0, OFS_CLR0: rd_word[SUM_BIT:0] = {summary, flags[N_WAKE-1:0]};
      OFS_STAT1:           rd_word[N_STATE-1:0] = flags[IDX_FL-1:IDX_ST];
      OFS_STAT2:           rd_word[N_FAIL-1:0] = flags[N_SRC-1:IDX_FL];
      OFS_MASK:            rd_word[N_SRC-1:0] = mask;
      OFS_INFO:            rd_word[INFO_CFG:0] = {cfg_sel, pend, st, alert_oe};
      default:             rd_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_fire)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // Helper counters of low and high time on the pin
  logic [TMR_W-1:0] low_cnt;
  logic [TMR_W-1:0] gap_cnt;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      low_cnt <= '0;
      gap_cnt <= TMR_W'(TIMEOUT_CYC);
    end
    else
    begin
      low_cnt <= alert_oe ? low_cnt + 1'b1 : '0;
      if (alert_oe)
        gap_cnt <= '0;
      else if (gap_cnt != TMR_W'(TIMEOUT_CYC))
        gap_cnt <= gap_cnt + 1'b1;
    end
  end

  a_min_pulse_width : assert property (@(posedge clk) disable iff (reset)
    $fell(alert_oe) && reset_out_line |-> low_cnt >= TMR_W'(MIN_PULSE_CYC))
    else $error("alert pulse too short");
  a_timeout_bound : assert property (@(posedge clk) disable iff (reset)
    alert_oe |-> low_cnt < TMR_W'(TIMEOUT_CYC)) else $error("alert held past timeout");
  a_gap_spacing : assert property (@(posedge clk) disable iff (reset)
    $rose(alert_oe) |-> gap_cnt >= TMR_W'(TIMEOUT_CYC)) else $error("alert gap too short");
  a_event_alerts : assert property (@(posedge clk) disable iff (reset)
    (|alert_ev) && mode_ok && st == ST_IDLE && !pend |-> ##2 alert_oe)
    else $error("enabled event gave no alert");
  a_mode_gate : assert property (@(posedge clk) disable iff (reset)
    !mode_ok && !pend |=> !(st == ST_LOW && $past(st) == ST_IDLE)) else $error("alert outside mode");
  a_restart_masks : assert property (@(posedge clk) disable iff (reset)
    restart_exit |=> mask == MASK_ALL) else $error("masks not enabled after restart");
  a_summary_clear : assert property (@(posedge clk) disable iff (reset)
    rd_clr ##1 (flags[N_SRC-1:IDX_ST] == '0) |-> !summary) else $error("summary stuck");
  a_swon_flag : assert property (@(posedge clk) disable iff (reset)
    aux2_on_cmd |=> flags[IDX_AUX2_UV]) else $error("switch-on flag not set");
  a_uv_hold : assert property (@(posedge clk) disable iff (reset)
    flags[IDX_AUX2_UV] && lvl[IDX_AUX2_UV] && rd_clr |=> flags[IDX_AUX2_UV])
    else $error("undervoltage flag cleared while present");
  a_read_release : assert property (@(posedge clk) disable iff (reset)
    st == ST_LOW && rd_clr && short_done |=> ##1 !alert_oe) else $error("read did not release");
  a_cfg_sample : assert property (@(posedge clk) disable iff (reset)
    !reset_out_line |=> cfg_sel == $past(alert_in) && !alert_oe) else $error("config not sampled");

  c_read_release : cover property (@(posedge clk) disable iff (reset) go_gap && rd_seen);
  c_timeout : cover property (@(posedge clk) disable iff (reset) go_gap && !rd_seen && !rd_clr);
  c_merge : cover property (@(posedge clk) disable iff (reset) st == ST_LOW && (|alert_ev));
  c_restart : cover property (@(posedge clk) disable iff (reset) restart_exit);
endmodule // sil_interrupt_logic

//--- sil_interrupt_logic_tb.sv
// Self-checking bench for the interrupt logic over its register bus and alert pin
`timescale 1ns/1ps
module sil_interrupt_logic_tb;
  import sil_pkg::*;
  // Short timeout keeps the run small while staying above the minimum pulse
  localparam int TO = 400;
  logic        clk            = 1'h0;
  logic        reset          = 1'h1;
  logic [7:0]  awaddr         = 8'h00;
  logic [7:0]  araddr         = 8'h00;
  logic [31:0] wdata          = 32'h0;
  logic        awvalid        = 1'h0;
  logic        wvalid         = 1'h0;
  logic        bready         = 1'h0;
  logic        arvalid        = 1'h0;
  logic        rready         = 1'h0;
  sil_src_s    src            = '0;
  logic        aux2_en        = 1'h0;
  logic        aux2_on_cmd    = 1'h0;
  logic        sw_dev_mode    = 1'h0;
  logic        reset_out_line = 1'h0;
  logic        cfg_level      = 1'h1;
  sil_mode_t   sbc_mode       = MODE_INIT;
  logic        awready, wready, bvalid, arready, rvalid, alert_wire, alert_oe, cfg_sel, alert_out;
  logic [1:0]  bresp, rresp, r, b;
  logic [31:0] rdata, d;
  int          failures       = 0;
  int          checked        = 0;
  int          n, w;

  // Free-running system clock
  always #25 clk = ~clk;

  sil_interrupt_logic #(.TIMEOUT_CYC(TO)) i_dut
  (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src(src), .aux2_en(aux2_en), .aux3_en(1'h0), .aux2_on_cmd(aux2_on_cmd), .aux3_on_cmd(1'h0),
    .sbc_mode(sbc_mode), .sw_dev_mode(sw_dev_mode), .reset_out_line(reset_out_line),
    .alert_in(alert_wire), .alert_out(alert_out), .alert_oe(alert_oe), .cfg_sel(cfg_sel)
  );

  sil_host_model i_host
  (
    .alert_oe(alert_oe), .reset_out_line(reset_out_line), .cfg_level(cfg_level), .alert_wire(alert_wire)
  );

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and stop
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Register read; ready level is held until the answer is sampled
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // Register write; address and data are released each on its own handshake
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (pa || pw)
    begin
      @(posedge clk);
      if (awready)
        pa = 1'h0;
      if (wready)
        pw = 1'h0;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge clk); while (!bvalid);
    b = bresp;
    bready <= 1'h0;
  endtask

  // Wait up to lim cycles for an alert, then measure its width; w stays 0 if none
  task pulse(input int lim);
    n = 0;
    w = 0;
    while (!alert_oe && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    while (alert_oe)
    begin
      @(posedge clk);
      w++;
    end
  endtask

  // Watchdog sized well above the longest sequence
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    repeat (3) @(posedge clk);
    chk(cfg_sel, 1'h1);
    cfg_level <= 1'h0;
    reset_out_line <= 1'h1;
    sbc_mode <= MODE_NORMAL;
    repeat (3) @(posedge clk);
    chk(cfg_sel, 1'h1);
    rd(OFS_MASK);
    chk(d, 32'h7FFF);
    rd(8'h40);
    chk(r, RESP_SLVERR);
    $display("test reset done");
    // Early clear read must not shorten the pulse below the minimum width
    src.wake[0] <= 1'h1;
    fork
      pulse(100);
      begin
        repeat (6) @(posedge clk);
        rd(OFS_CLR0);
      end
    join
    chk(d, 32'h1);
    chk(w >= MIN_PULSE_CYC && w <= MIN_PULSE_CYC + 2, 1'h1);
    rd(OFS_STAT0);
    chk(d, 32'h0);
    $display("test early read done");
    // Two state sources at once, no read: one pulse of full timeout
    repeat (TO) @(posedge clk);
    src.state[1:0] <= 2'h3;
    pulse(100);
    chk(w, TO);
    rd(OFS_STAT1);
    chk(d, 32'h3);
    rd(OFS_STAT0);
    chk(d, 32'h10);
    pulse(TO + 50);
    chk(w, 0);
    rd(OFS_CLR0);
    rd(OFS_STAT1);
    chk(d, 32'h3);
    src.state[1:0] <= 2'h0;
    rd(OFS_CLR0);
    rd(OFS_STAT0);
    chk(d, 32'h0);
    $display("test timeout done");
    // Event during the gap waits for it to expire
    src.wake[2] <= 1'h1;
    pulse(TO + 100);
    chk(w, TO);
    src.wake[3] <= 1'h1;
    pulse(TO + 100);
    chk(n >= TO - 2 && n <= TO + 5, 1'h1);
    rd(OFS_CLR0);
    chk(d, 32'hC);
    rd(OFS_STAT0);
    chk(d, 32'h0);
    $display("test gap done");
    // Masked source flags only
    wr(OFS_MASK, 32'h7FFD);
    rd(OFS_MASK);
    chk(d, 32'h7FFD);
    chk(b, RESP_OKAY);
    chk(alert_out, 1'h0);
    src.wake[1] <= 1'h1;
    pulse(TO);
    chk(w, 0);
    rd(OFS_STAT0);
    chk(d, 32'h2);
    sbc_mode <= MODE_RESTART;
    repeat (2) @(posedge clk);
    sbc_mode <= MODE_NORMAL;
    rd(OFS_MASK);
    chk(d, 32'h7FFF);
    $display("test mask done");
    // Modes: silent in init, reset event needs development mode
    sbc_mode <= MODE_INIT;
    src.fail[0] <= 1'h1;
    pulse(TO);
    chk(w, 0);
    sbc_mode <= MODE_STOP;
    src.fail[1] <= 1'h1;
    pulse(TO);
    chk(w, 0);
    src.fail[1] <= 1'h0;
    sw_dev_mode <= 1'h1;
    @(posedge clk);
    src.fail[1] <= 1'h1;
    pulse(TO + 100);
    chk(w, TO);
    rd(OFS_STAT2);
    chk(d, 32'h3);
    rd(OFS_CLR0);
    rd(OFS_STAT2);
    chk(d, 32'h0);
    $display("test modes done");
    // Regulator switch-on with undervoltage still present
    sbc_mode <= MODE_NORMAL;
    src.state[5] <= 1'h1;
    pulse(TO + 100);
    chk(w, 0);
    aux2_en <= 1'h1;
    aux2_on_cmd <= 1'h1;
    @(posedge clk);
    aux2_on_cmd <= 1'h0;
    pulse(TO + 100);
    chk(w, TO);
    rd(OFS_CLR0);
    rd(OFS_STAT1);
    chk(d, 32'h20);
    src.state[5] <= 1'h0;
    pulse(TO + 100);
    chk(w, TO);
    rd(OFS_CLR0);
    rd(OFS_STAT1);
    chk(d, 32'h0);
    $display("test switch-on done");
    end_of_test();
  end
endmodule // sil_interrupt_logic_tb

//--- sil_pkg.sv
// Shared constants and types for the SBC interrupt logic
package sil_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_STAT0 = 8'h00;
  localparam logic [7:0] OFS_STAT1 = 8'h04;
  localparam logic [7:0] OFS_STAT2 = 8'h08;
  localparam logic [7:0] OFS_MASK  = 8'h0C;
  localparam logic [7:0] OFS_CLR0  = 8'h10;
  localparam logic [7:0] OFS_INFO  = 8'h14;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Source layout: wake [3:0], state type [11:4], failure events [14:12]
  localparam int N_WAKE      = 4;
  localparam int N_STATE     = 8;
  localparam int N_FAIL      = 3;
  localparam int N_SRC       = 15;
  localparam int IDX_ST      = 4;
  localparam int IDX_FL      = 12;
  localparam int IDX_AUX2_UV = 9;
  localparam int IDX_AUX3_UV = 10;
  localparam int IDX_RST_EV  = 13;
  localparam int SUM_BIT     = 4;
  localparam int INFO_CFG    = 5;
  localparam logic [N_SRC-1:0] MASK_ALL = 15'h7FFF;
  localparam logic [N_SRC-1:0] UV_BITS  = 15'h0600;

  // Operating modes reported by the chip state machine
  typedef logic [2:0] sil_mode_t;
  localparam sil_mode_t MODE_INIT    = 3'h0;
  localparam sil_mode_t MODE_NORMAL  = 3'h1;
  localparam sil_mode_t MODE_STOP    = 3'h2;
  localparam sil_mode_t MODE_RESTART = 3'h3;

  // Timing
  localparam int CLK_HZ            = 20000000;
  localparam int ALERT_TIMEOUT_MS  = 6;
  localparam int ALERT_TIMEOUT_CYC = ALERT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int MIN_PULSE_US      = 10;
  localparam int MIN_PULSE_CYC     = (MIN_PULSE_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int TMR_W             = 17;

  // Source levels from the detection circuits
  typedef struct packed {
    logic [N_FAIL-1:0]  fail;   // Serial fail, reset, watchdog setting fault
    logic [N_STATE-1:0] state;  // Prewarn, aux2 ot, can ot, can, lin, aux2 uv, aux3 uv, aux3 oc
    logic [N_WAKE-1:0]  wake;   // Can, lin, wake pin, periodic
  } sil_src_s;

  // Alert pin sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_GAP  = 3'b100
  } sil_alert_e;

endpackage

//--- sil_timer.sv
// Restartable saturating cycle timer
`timescale 1ns/1ps
module sil_timer
#(
  parameter int WIDTH = 17,  // Counter width
  parameter int COUNT = 100  // Cycles after restart until done
)(
  input  wire logic clk,     // System clock
  input  wire logic reset,   // Async reset, active high
  input  wire logic restart, // Start counting from zero
  output logic      done     // Count reached, stays high
);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT);
  logic [WIDTH-1:0] cnt;

  // Saturates so done stays true while idle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt <= LAST;
    else if (restart)
      cnt <= '0;
    else if (cnt != LAST)
      cnt <= cnt + 1'b1;
  end

  assign done = (cnt == LAST);

  a_timer_done : assert property (@(posedge clk) disable iff (reset)
    restart |=> !done) else $error("timer done right after restart");
endmodule // sil_timer
